// >>> src/emsdh_consts.vh
// Constants for the SDRAM strobe, peripheral transfer and bus surrender block
`ifndef EMSDH_CONSTS_VH
`define EMSDH_CONSTS_VH

// Interface clock source select codes
`define EMSDH_SRC_EXT       2'h0
`define EMSDH_SRC_DIV4      2'h1
`define EMSDH_SRC_DIV6      2'h2

// Divider terminal counts and high-phase lengths, in system clock cycles
`define EMSDH_DIV4_LAST     3'h3
`define EMSDH_DIV6_LAST     3'h5
`define EMSDH_DIV4_HALF     3'h2
`define EMSDH_DIV6_HALF     3'h3

// User command codes
`define EMSDH_CMD_ACTIVATE  3'h0
`define EMSDH_CMD_READ      3'h1
`define EMSDH_CMD_WRITE     3'h2
`define EMSDH_CMD_DEACT_ALL 3'h3
`define EMSDH_CMD_DEACT_ONE 3'h4
`define EMSDH_CMD_AUTO_REF  3'h5
`define EMSDH_CMD_MODE_SET  3'h6
`define EMSDH_CMD_SELF_REF  3'h7

// SDRAM command encodings as {row strobe, column strobe, write strobe}, active low
`define EMSDH_ENC_NOP       3'h7
`define EMSDH_ENC_ACTIVATE  3'h3
`define EMSDH_ENC_READ      3'h5
`define EMSDH_ENC_WRITE     3'h4
`define EMSDH_ENC_DEACT     3'h2
`define EMSDH_ENC_REFRESH   3'h1
`define EMSDH_ENC_MODE_SET  3'h0

// Address bit that selects all banks on a deactivate
`define EMSDH_ADDR_ALLBANK  5'h0a

// Timing in interface clock periods
`define EMSDH_CAS_LATENCY   3'h3
`define EMSDH_HOLD_MIN_E    3'h2

`endif

// >>> src/emsdh_ifclk.v
// Interface clock generator: external clock follower or system clock divider
`timescale 1ns/1ps
`default_nettype none
`include "emsdh_consts.vh"

module emsdh_ifclk (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Source selection
   input  wire [1:0] src_sel,
   input  wire       ext_clk,
   // Interface clock rising-edge enable and level
   output wire       tick,
   output reg        clk_lvl
);

   reg  [2:0] cnt_q;
   reg        ext_q;
   wire       use_ext  = (src_sel == `EMSDH_SRC_EXT);
   wire       use_div6 = (src_sel == `EMSDH_SRC_DIV6);
   wire [2:0] div_last = use_div6 ? `EMSDH_DIV6_LAST : `EMSDH_DIV4_LAST;
   wire [2:0] div_half = use_div6 ? `EMSDH_DIV6_HALF : `EMSDH_DIV4_HALF;
   wire       div_wrap = (cnt_q >= div_last);
   wire [2:0] cnt_d    = div_wrap ? 3'h0 : cnt_q + 3'h1;

   // Tick marks the system edge on which clk_lvl rises
   assign tick = use_ext ? (ext_clk & ~ext_q) : div_wrap;

   always @(posedge clk) begin
      if (rst) begin
         cnt_q   <= 3'h0;
         ext_q   <= 1'b0;
         clk_lvl <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         ext_q   <= ext_clk;
         clk_lvl <= use_ext ? ext_clk : (cnt_d < div_half);
      end
   end

endmodule // emsdh_ifclk
`default_nettype wire

// >>> src/emsdh_lat_dly.v
// Programmable 0 to 3 interface-period delay for the transfer strobe
`timescale 1ns/1ps
`default_nettype none

module emsdh_lat_dly (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Interface clock enable
   input  wire       tick,
   // Latency code and data-phase marker
   input  wire [1:0] lat,
   input  wire       phase_in,
   // Delayed marker and pending flag
   output wire       strobe,
   output wire       busy
);

   reg [2:0] sr_q;

   assign strobe = (lat == 2'h0) ? phase_in :
                   (lat == 2'h1) ? sr_q[0] :
                   (lat == 2'h2) ? sr_q[1] : sr_q[2];
   assign busy   = |sr_q;

   always @(posedge clk) begin
      if (rst) begin
         sr_q <= 3'h0;
      end else if (tick) begin
         sr_q <= {sr_q[1:0], phase_in};
      end
   end

endmodule // emsdh_lat_dly
`default_nettype wire

// >>> src/emsdh_top.v
// SDRAM command strobes, peripheral transfer strobe and bus surrender handshake
//
// Operation
// - Shared strobes act as column, write, row.
// - Supports all seven SDRAM commands plus self-refresh.
// - All SDRAM outputs change on clock rise.
// - Read data sampled on memory clock rise.
// - Transfer strobe only for peripheral-transfer DMA.
// - Peripheral-transfer read data is not captured.
// - Peripheral-transfer write leaves data bus floating.
// - Read strobe delayed 0-3 by latency code.
// - Write strobe delayed 0-3 by latency code.
// - Grant only after pending transactions complete.
// - Surrender disable blocks new surrender entry from idle.
// - Clock outputs toggle or float per select.
// - Float two periods after request; grant on the same edge.
// - Redrive 2-7 periods after release; grant released on the same edge.
// - Floated clocks follow the same surrender timing.
// - All listed bus signals float during surrender.
// - Interface clock: external, CPU/4 or CPU/6.
`timescale 1ns/1ps
`default_nettype none
`include "emsdh_consts.vh"

module emsdh_top (
   // System clock and reset
   input  wire        CLK_SYS,
   input  wire        RST,
   // Configuration
   input  wire [1:0]  IF_CLK_SRC,
   input  wire        EXT_IF_CLOCK_IN,
   input  wire [1:0]  PXFER_READ_LATENCY,
   input  wire [1:0]  PXFER_WRITE_LATENCY,
   input  wire        SURRENDER_DISABLE,
   input  wire [1:0]  CLKOUT_FLOAT_SEL,
   // User command port
   input  wire        CMD_VALID,
   input  wire [2:0]  CMD_CODE,
   input  wire [1:0]  CMD_CHIP,
   input  wire [19:0] CMD_ADDR,
   input  wire [7:0]  CMD_BE_N,
   input  wire [63:0] CMD_WDATA,
   input  wire        CMD_PXFER,
   output wire        CMD_ACK,
   // Read return and status
   output wire [63:0] RD_DATA,
   output wire        RD_VALID,
   output wire        SELF_REFRESH_ACTIVE,
   // Memory bus
   output wire [3:0]  MEM_CHIP_SELECT_N,
   output wire [7:0]  MEM_BYTE_ENABLE_N,
   output wire [19:0] MEM_ADDR_BUS,
   output wire [63:0] MEM_DATA_OUT,
   output wire        MEM_DATA_OE,
   input  wire [63:0] MEM_DATA_IN,
   output wire        SDRAM_ROW_STROBE_N,
   output wire        SDRAM_COL_STROBE_N,
   output wire        SDRAM_WRITE_STROBE_N,
   output wire        SDRAM_CLK_ENABLE,
   output wire        THIRD_OUTPUT_ENABLE_N,
   output wire        PERIPH_XFER_STROBE_N,
   output wire        MEM_BUS_OE,
   // Memory clock outputs
   output wire [1:0]  MEM_CLOCK_OUT,
   output wire [1:0]  MEM_CLOCK_OE,
   // Bus surrender handshake
   input  wire        SURR_REQ_N,
   output wire        SURR_GRANT_N
);

   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_RDWAIT = 3'h1;
   localparam [2:0] ST_SELF   = 3'h2;
   localparam [2:0] ST_HENTER = 3'h3;
   localparam [2:0] ST_HOLD   = 3'h4;
   localparam [2:0] ST_HEXIT  = 3'h5;

   // Interface clock
   wire        tick;
   wire        clk_lvl;

   // State and counters
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [2:0]  rd_cnt_q;
   reg  [2:0]  rd_cnt_d;
   reg  [2:0]  hcnt_q;
   reg  [2:0]  hcnt_d;
   reg         pxfer_q;
   reg         pxfer_d;

   // Registered pin values
   reg  [3:0]  cs_n_q;
   reg  [3:0]  cs_n_d;
   reg  [2:0]  enc_q;
   reg  [2:0]  enc_d;
   reg  [7:0]  be_n_q;
   reg  [7:0]  be_n_d;
   reg  [19:0] addr_q;
   reg  [19:0] addr_d;
   reg  [63:0] wdata_q;
   reg  [63:0] wdata_d;
   reg         data_oe_q;
   reg         data_oe_d;
   reg         cke_q;
   reg         cke_d;
   reg         bus_oe_q;
   reg         bus_oe_d;
   reg  [1:0]  clk_oe_q;
   reg  [1:0]  clk_oe_d;
   reg         grant_n_q;
   reg         grant_n_d;
   reg         pxs_n_q;
   reg         self_ref_q;
   reg         ack_q;
   reg         ack_d;
   reg  [63:0] rd_data_q;
   reg         rd_valid_q;
   reg         rd_valid_d;
   reg         rd_phase;
   reg         wr_phase;

   wire        rd_strobe;
   wire        wr_strobe;
   wire        rd_busy;
   wire        wr_busy;
   wire        hold_req = ~SURR_REQ_N;
   wire        pending  = rd_busy | wr_busy;
   wire [3:0]  cs_sel_n = ~(4'h1 << CMD_CHIP);

   // Interface clock from external pin or system divider
   emsdh_ifclk u_ifclk (
      .clk     (CLK_SYS),
      .rst     (RST),
      .src_sel (IF_CLK_SRC),
      .ext_clk (EXT_IF_CLOCK_IN),
      .tick    (tick),
      .clk_lvl (clk_lvl)
   );

   // Strobe delay after the read data phase
   emsdh_lat_dly u_rd_dly (
      .clk      (CLK_SYS),
      .rst      (RST),
      .tick     (tick),
      .lat      (PXFER_READ_LATENCY),
      .phase_in (rd_phase),
      .strobe   (rd_strobe),
      .busy     (rd_busy)
   );

   // Strobe delay after the write data phase
   emsdh_lat_dly u_wr_dly (
      .clk      (CLK_SYS),
      .rst      (RST),
      .tick     (tick),
      .lat      (PXFER_WRITE_LATENCY),
      .phase_in (wr_phase),
      .strobe   (wr_strobe),
      .busy     (wr_busy)
   );

   always @* begin
      state_d    = state_q;
      rd_cnt_d   = rd_cnt_q;
      hcnt_d     = hcnt_q;
      pxfer_d    = pxfer_q;
      cs_n_d     = 4'hf;
      enc_d      = `EMSDH_ENC_NOP;
      be_n_d     = 8'h00;
      addr_d     = addr_q;
      wdata_d    = wdata_q;
      data_oe_d  = 1'b0;
      cke_d      = cke_q;
      bus_oe_d   = bus_oe_q;
      clk_oe_d   = clk_oe_q;
      grant_n_d  = grant_n_q;
      ack_d      = 1'b0;
      rd_valid_d = 1'b0;
      rd_phase   = 1'b0;
      wr_phase   = 1'b0;
      if (tick) begin
         case (state_q)
            ST_IDLE: begin
               // Surrender wins over a new command; accepted work drains first
               if (hold_req && !SURRENDER_DISABLE && !pending) begin
                  state_d = ST_HENTER;
                  hcnt_d  = 3'h1;
               end else if (CMD_VALID) begin
                  ack_d   = 1'b1;
                  cs_n_d  = cs_sel_n;
                  addr_d  = CMD_ADDR;
                  pxfer_d = CMD_PXFER;
                  case (CMD_CODE)
                     `EMSDH_CMD_ACTIVATE: begin
                        enc_d = `EMSDH_ENC_ACTIVATE;
                     end
                     `EMSDH_CMD_READ: begin
                        enc_d    = `EMSDH_ENC_READ;
                        rd_cnt_d = 3'h1;
                        state_d  = ST_RDWAIT;
                     end
                     `EMSDH_CMD_WRITE: begin
                        enc_d     = `EMSDH_ENC_WRITE;
                        be_n_d    = CMD_BE_N;
                        wdata_d   = CMD_WDATA;
                        data_oe_d = ~CMD_PXFER;
                        wr_phase  = CMD_PXFER;
                     end
                     `EMSDH_CMD_DEACT_ALL: begin
                        enc_d = `EMSDH_ENC_DEACT;
                        addr_d[`EMSDH_ADDR_ALLBANK] = 1'b1;
                     end
                     `EMSDH_CMD_DEACT_ONE: begin
                        enc_d = `EMSDH_ENC_DEACT;
                        addr_d[`EMSDH_ADDR_ALLBANK] = 1'b0;
                     end
                     `EMSDH_CMD_AUTO_REF: begin
                        enc_d = `EMSDH_ENC_REFRESH;
                     end
                     `EMSDH_CMD_MODE_SET: begin
                        enc_d = `EMSDH_ENC_MODE_SET;
                     end
                     default: begin
                        // Self-refresh entry: refresh with clock enable dropped
                        enc_d   = `EMSDH_ENC_REFRESH;
                        cke_d   = 1'b0;
                        state_d = ST_SELF;
                     end
                  endcase
               end
            end
            ST_RDWAIT: begin
               if (rd_cnt_q == `EMSDH_CAS_LATENCY) begin
                  rd_phase = pxfer_q;
               end
               if (rd_cnt_q == `EMSDH_CAS_LATENCY + 3'h1) begin
                  rd_valid_d = ~pxfer_q;
                  state_d    = ST_IDLE;
               end else begin
                  rd_cnt_d = rd_cnt_q + 3'h1;
               end
            end
            ST_SELF: begin
               // Only the self-refresh code leaves; other commands wait
               if (CMD_VALID && (CMD_CODE == `EMSDH_CMD_SELF_REF)) begin
                  ack_d   = 1'b1;
                  cke_d   = 1'b1;
                  state_d = ST_IDLE;
               end
            end
            ST_HENTER: begin
               if (!hold_req) begin
                  state_d = ST_IDLE;
               end else if (hcnt_q == `EMSDH_HOLD_MIN_E) begin
                  bus_oe_d  = 1'b0;
                  clk_oe_d  = ~CLKOUT_FLOAT_SEL;
                  grant_n_d = 1'b0;
                  state_d   = ST_HOLD;
               end else begin
                  hcnt_d = hcnt_q + 3'h1;
               end
            end
            ST_HOLD: begin
               // Grant stays low until the master lets go
               if (!hold_req) begin
                  state_d = ST_HEXIT;
                  hcnt_d  = 3'h1;
               end
            end
            ST_HEXIT: begin
               // Fixed at two periods, well inside the seven allowed
               if (hcnt_q == `EMSDH_HOLD_MIN_E) begin
                  bus_oe_d  = 1'b1;
                  clk_oe_d  = 2'h3;
                  grant_n_d = 1'b1;
                  state_d   = ST_IDLE;
               end else begin
                  hcnt_d = hcnt_q + 3'h1;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // Memory pin registers move only on the interface clock rising edge; ack and read valid drop one system cycle later
   always @(posedge CLK_SYS) begin
      if (RST) begin
         state_q    <= ST_IDLE;
         rd_cnt_q   <= 3'h0;
         hcnt_q     <= 3'h0;
         pxfer_q    <= 1'b0;
         cs_n_q     <= 4'hf;
         enc_q      <= `EMSDH_ENC_NOP;
         be_n_q     <= 8'h00;
         addr_q     <= 20'h00000;
         wdata_q    <= 64'h0000000000000000;
         data_oe_q  <= 1'b0;
         cke_q      <= 1'b1;
         bus_oe_q   <= 1'b1;
         clk_oe_q   <= 2'h3;
         grant_n_q  <= 1'b1;
         pxs_n_q    <= 1'b1;
         self_ref_q <= 1'b0;
         ack_q      <= 1'b0;
         rd_data_q  <= 64'h0000000000000000;
         rd_valid_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         rd_cnt_q   <= rd_cnt_d;
         hcnt_q     <= hcnt_d;
         pxfer_q    <= pxfer_d;
         ack_q      <= ack_d;
         rd_valid_q <= rd_valid_d;
         bus_oe_q   <= bus_oe_d;
         clk_oe_q   <= clk_oe_d;
         grant_n_q  <= grant_n_d;
         if (tick) begin
            cs_n_q    <= cs_n_d;
            enc_q     <= enc_d;
            be_n_q    <= be_n_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            // Data pins need both the write drive and bus ownership
            data_oe_q <= data_oe_d & bus_oe_d;
            cke_q     <= cke_d;
            self_ref_q <= ~cke_d;
            pxs_n_q   <= ~(rd_strobe | wr_strobe);
         end
         if (rd_valid_d) begin
            rd_data_q <= MEM_DATA_IN;
         end
      end
   end

   assign CMD_ACK               = ack_q;
   assign RD_DATA               = rd_data_q;
   assign RD_VALID              = rd_valid_q;
   assign SELF_REFRESH_ACTIVE   = self_ref_q;
   assign MEM_CHIP_SELECT_N     = cs_n_q;
   assign MEM_BYTE_ENABLE_N     = be_n_q;
   assign MEM_ADDR_BUS          = addr_q;
   assign MEM_DATA_OUT          = wdata_q;
   assign MEM_DATA_OE           = data_oe_q;
   // Strobe bits: row, column, write
   assign SDRAM_ROW_STROBE_N    = enc_q[2];
   assign SDRAM_COL_STROBE_N    = enc_q[1];
   assign SDRAM_WRITE_STROBE_N  = enc_q[0];
   assign SDRAM_CLK_ENABLE      = cke_q;
   assign THIRD_OUTPUT_ENABLE_N = 1'b1;
   assign PERIPH_XFER_STROBE_N  = pxs_n_q;
   assign MEM_BUS_OE            = bus_oe_q;
   assign MEM_CLOCK_OUT         = {2{clk_lvl}};
   assign MEM_CLOCK_OE          = clk_oe_q;
   assign SURR_GRANT_N          = grant_n_q;

endmodule // emsdh_top
`default_nettype wire

// >>> tb/emsdh_top_properties.sv
// Port-level checks for the SDRAM strobe, transfer strobe and surrender block
`timescale 1ns/1ps
`default_nettype none
`include "emsdh_consts.vh"
module emsdh_props (
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RST,
   // Configuration and command
   input wire logic        SURRENDER_DISABLE,
   input wire logic [1:0]  CLKOUT_FLOAT_SEL,
   input wire logic        CMD_ACK,
   input wire logic [2:0]  CMD_CODE,
   input wire logic [1:0]  CMD_CHIP,
   input wire logic        CMD_PXFER,
   input wire logic [63:0] CMD_WDATA,
   // Memory side
   input wire logic [3:0]  MEM_CHIP_SELECT_N,
   input wire logic [63:0] MEM_DATA_OUT,
   input wire logic        MEM_DATA_OE,
   input wire logic        SDRAM_ROW_STROBE_N,
   input wire logic        SDRAM_COL_STROBE_N,
   input wire logic        SDRAM_WRITE_STROBE_N,
   input wire logic        PERIPH_XFER_STROBE_N,
   input wire logic        MEM_BUS_OE,
   input wire logic [1:0]  MEM_CLOCK_OUT,
   input wire logic [1:0]  MEM_CLOCK_OE,
   // Surrender handshake
   input wire logic        SURR_REQ_N,
   input wire logic        SURR_GRANT_N
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic [5:0] lo_q;
   logic       px_q;
   // Saturating count of cycles the request has been low
   always @(posedge CLK_SYS) begin
      lo_q <= (RST || SURR_REQ_N) ? 6'h0 : lo_q + {5'h0, lo_q != 6'h3f};
      px_q <= RST ? 1'b0 : (CMD_ACK && $past(CMD_PXFER)) ? 1'b1 : $rose(PERIPH_XFER_STROBE_N) ? 1'b0 : px_q;
   end
   function automatic logic [2:0] enc_of(input logic [2:0] c);
      case (c)
         3'h0: enc_of = 3'h3;
         3'h1: enc_of = 3'h5;
         3'h2: enc_of = 3'h4;
         3'h3, 3'h4: enc_of = 3'h2;
         3'h5: enc_of = 3'h1;
         default: enc_of = 3'h0;
      endcase
   endfunction
   // Command inputs may change once the ack is seen, so the taken values are one cycle back
   a_cmd_encoding: assert property (CMD_ACK && $past(CMD_CODE) != 3'h7 |->
      {SDRAM_ROW_STROBE_N, SDRAM_COL_STROBE_N, SDRAM_WRITE_STROBE_N} == enc_of($past(CMD_CODE))
      && MEM_CHIP_SELECT_N == ~(4'h1 << $past(CMD_CHIP))) else $error("command pins wrong");
   a_pins_on_tick: assert property ($changed(MEM_CHIP_SELECT_N) || $rose(CMD_ACK) |->
      $rose(MEM_CLOCK_OUT[0])) else $error("pins changed off the clock rise");
   a_write_drive: assert property (CMD_ACK && $past(CMD_CODE) == 3'h2 |->
      MEM_DATA_OE == !$past(CMD_PXFER) && ($past(CMD_PXFER) || MEM_DATA_OUT == $past(CMD_WDATA)))
      else $error("write data drive wrong");
   a_pxfer_only: assert property ($fell(PERIPH_XFER_STROBE_N) |-> px_q || CMD_ACK && $past(CMD_PXFER))
      else $error("transfer strobe without transfer");
   a_hold_waits: assert property ($fell(SURR_GRANT_N) |-> !px_q && PERIPH_XFER_STROBE_N)
      else $error("grant while strobe pending");
   a_surrender_disable_set: assert property (SURRENDER_DISABLE && SURR_GRANT_N |=> SURR_GRANT_N)
      else $error("grant while disabled");
   a_float_grant: assert property ((MEM_BUS_OE == SURR_GRANT_N) && (MEM_BUS_OE || !MEM_DATA_OE))
      else $error("bus drive and grant disagree");
   a_float_delay: assert property ($fell(SURR_GRANT_N) |-> lo_q >= 6'h08)
      else $error("float too soon after request");
   a_resume_window: assert property ($rose(SURR_REQ_N) && !SURR_GRANT_N |->
      !SURR_GRANT_N [*8] ##[1:29] SURR_GRANT_N) else $error("resume outside window");
   a_clock_float: assert property (MEM_CLOCK_OE == (SURR_GRANT_N ? 2'h3 : ~CLKOUT_FLOAT_SEL))
      else $error("clock drive enable wrong");
endmodule // emsdh_props
bind emsdh_top emsdh_props u_emsdh_props (.*);
`default_nettype wire

// >>> tb/emsdh_sdram_model.sv
// SDRAM read data source watching the memory pins
`timescale 1ns/1ps
`default_nettype none
module emsdh_sdram_model (
   // Clocks
   input  wire logic        clk,
   input  wire logic        mck,
   // Command pins
   input  wire logic [3:0]  cs_n,
   input  wire logic [2:0]  cmd,
   // Data pins and the word last returned
   output var  logic [63:0] dq,
   output var  logic [63:0] word
);
   logic       mck_q = 1'b0;
   logic [2:0] pipe = 3'h0;
   initial dq = 64'h0;
   initial word = 64'h0f1e2d3c4b5a6978;
   // Rise judged one cycle late so the pins it launched have settled
   always @(posedge clk) begin
      mck_q <= mck;
      if (mck && !mck_q) begin
         pipe <= {pipe[1:0], cs_n != 4'hf && cmd == 3'h5};
         if (cs_n != 4'hf && cmd == 3'h5) word <= word + 64'h0101;
         // Valid over the fourth rise only, otherwise a running pattern that never matches the word
         dq <= pipe[2] ? word : dq + 64'h1111;
      end
   end
endmodule // emsdh_sdram_model
`default_nettype wire

// >>> tb/ext_mem_sdram_pdt_bus_hold_tb.sv
// Self-checking testbench for the SDRAM strobe and surrender block
`timescale 1ns/1ps
`default_nettype none
module ext_mem_sdram_pdt_bus_hold_tb;
   logic        CLK_SYS = 1'b0, RST = 1'b1, EXT_IF_CLOCK_IN = 1'b0, SURRENDER_DISABLE = 1'b0;
   logic        CMD_VALID = 1'b0, CMD_PXFER = 1'b0, SURR_REQ_N = 1'b1;
   logic [1:0]  IF_CLK_SRC = 2'h1, PXFER_READ_LATENCY = 2'h0, PXFER_WRITE_LATENCY = 2'h0;
   logic [1:0]  CLKOUT_FLOAT_SEL = 2'h0, CMD_CHIP = 2'h0;
   logic [2:0]  CMD_CODE = 3'h0;
   logic [19:0] CMD_ADDR = 20'h12345;
   logic [7:0]  CMD_BE_N = 8'h5a;
   logic [63:0] CMD_WDATA = 64'hfedcba9876543210;
   wire logic        CMD_ACK, RD_VALID, SELF_REFRESH_ACTIVE, MEM_DATA_OE, SDRAM_ROW_STROBE_N;
   wire logic        SDRAM_COL_STROBE_N, SDRAM_WRITE_STROBE_N, SDRAM_CLK_ENABLE, THIRD_OUTPUT_ENABLE_N;
   wire logic        PERIPH_XFER_STROBE_N, MEM_BUS_OE, SURR_GRANT_N;
   wire logic [63:0] RD_DATA, MEM_DATA_OUT, MEM_DATA_IN, rd_word;
   wire logic [3:0]  MEM_CHIP_SELECT_N;
   wire logic [7:0]  MEM_BYTE_ENABLE_N;
   wire logic [19:0] MEM_ADDR_BUS;
   wire logic [1:0]  MEM_CLOCK_OUT, MEM_CLOCK_OE;
   int   n_mismatch = 0, checks = 0, i, t, ts, rv, n;
   logic mq, tk;
   logic [2:0] enc [7] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
   emsdh_top u_emsdh_top (.*);
   emsdh_sdram_model u_emsdh_sdram_model (.clk(CLK_SYS), .mck(MEM_CLOCK_OUT[0]), .cs_n(MEM_CHIP_SELECT_N),
      .cmd({SDRAM_ROW_STROBE_N, SDRAM_COL_STROBE_N, SDRAM_WRITE_STROBE_N}), .dq(MEM_DATA_IN), .word(rd_word));
   initial forever #2 CLK_SYS = ~CLK_SYS;
   // Offset keeps external edges clear of system clock edges
   initial begin
      #1.3;
      forever #10 EXT_IF_CLOCK_IN = ~EXT_IF_CLOCK_IN;
   end
   task automatic tally_and_finish;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bound(input logic ok);
      if (ok !== 1'b1) begin
         chk(1'b0, 1'b1);
         tally_and_finish;
      end
   endtask
   task automatic step;
      mq = MEM_CLOCK_OUT[0];
      @(posedge CLK_SYS);
      #1;
      tk = MEM_CLOCK_OUT[0] && !mq;
   endtask
   task automatic issue(input logic [2:0] code, input logic [1:0] chip, input logic px);
      int k;
      // Let the previous ack cycle pass so no request signal is reassigned in one step
      if (CMD_ACK === 1'b1) step;
      CMD_CODE = code;
      CMD_CHIP = chip;
      CMD_PXFER = px;
      CMD_VALID = 1'b1;
      k = 0;
      do begin
         step;
         k++;
      end while (CMD_ACK !== 1'b1 && k < 100);
      bound(CMD_ACK);
      CMD_VALID = 1'b0;
   endtask
   task automatic xfer(input logic [2:0] code, input logic px, input logic [1:0] lat);
      PXFER_READ_LATENCY = lat;
      PXFER_WRITE_LATENCY = lat;
      issue(code, 2'h2, px);
      if (code == 3'h2) begin
         chk(MEM_DATA_OE, !px);
         chk(MEM_BYTE_ENABLE_N, CMD_BE_N);
         if (!px) chk(MEM_DATA_OUT, CMD_WDATA);
      end
      ts = -1;
      rv = 0;
      t = 0;
      for (i = 0; i < 48; i++) begin
         if (PERIPH_XFER_STROBE_N === 1'b0 && ts < 0) ts = t;
         if (RD_VALID === 1'b1) begin
            rv++;
            chk(RD_DATA, rd_word);
         end
         step;
         t += tk;
      end
      chk(rv, code == 3'h1 && !px);
      chk(ts, px ? (code == 3'h1 ? 3 : 0) + lat : -1);
   endtask
   task automatic s_hold(input logic [1:0] sel, input logic pend);
      logic sb;
      CLKOUT_FLOAT_SEL = sel;
      if (pend) begin
         PXFER_READ_LATENCY = 2'h3;
         issue(3'h1, 2'h0, 1'b1);
      end
      SURR_REQ_N = 1'b0;
      sb = 1'b0;
      n = 0;
      while (SURR_GRANT_N !== 1'b0 && n < 200) begin
         step;
         n++;
         sb |= !PERIPH_XFER_STROBE_N;
      end
      bound(!SURR_GRANT_N);
      chk(pend ? sb : n <= 13, 1'b1);
      chk({MEM_BUS_OE, MEM_DATA_OE, MEM_CLOCK_OE}, {2'h0, ~sel});
      repeat (4) step;
      SURR_REQ_N = 1'b1;
      n = 0;
      while (SURR_GRANT_N !== 1'b1 && n < 100) begin
         step;
         n++;
      end
      bound(SURR_GRANT_N);
      chk(n >= 8 && n <= 36, 1'b1);
      chk({MEM_BUS_OE, MEM_CLOCK_OE}, 3'h7);
   endtask
   task automatic next_tick;
      n = 0;
      do begin
         step;
         n++;
      end while (tk !== 1'b1 && n < 40);
      bound(tk);
   endtask
   initial begin
      repeat (3) step;
      RST = 1'b0;
      chk({SURR_GRANT_N, MEM_BUS_OE, MEM_CLOCK_OE}, 4'hf);
      for (int c = 0; c < 7; c++) begin
         issue(c[2:0], c[1:0], 1'b0);
         chk({SDRAM_ROW_STROBE_N, SDRAM_COL_STROBE_N, SDRAM_WRITE_STROBE_N}, enc[c]);
         chk(MEM_CHIP_SELECT_N, 4'hf ^ (4'h1 << c[1:0]));
         chk(MEM_ADDR_BUS, c == 3 ? 20'h12745 : 20'h12345);
      end
      issue(3'h7, 2'h1, 1'b0);
      chk({SELF_REFRESH_ACTIVE, SDRAM_CLK_ENABLE, SDRAM_ROW_STROBE_N, SDRAM_COL_STROBE_N,
           SDRAM_WRITE_STROBE_N}, 5'h11);
      repeat (8) step;
      issue(3'h7, 2'h1, 1'b0);
      chk({SELF_REFRESH_ACTIVE, SDRAM_CLK_ENABLE}, 2'h1);
      for (int p = 0; p < 8; p++) begin
         xfer(3'h1, p[2], p[1:0]);
         xfer(3'h2, p[2], p[1:0]);
      end
      SURRENDER_DISABLE = 1'b1;
      SURR_REQ_N = 1'b0;
      repeat (60) step;
      chk(SURR_GRANT_N, 1'b1);
      SURR_REQ_N = 1'b1;
      step;
      SURRENDER_DISABLE = 1'b0;
      s_hold(2'h1, 1'b1);
      s_hold(2'h2, 1'b0);
      for (int s = 0; s < 4; s++) begin
         IF_CLK_SRC = s[1:0];
         repeat (3) next_tick;
         chk(n, s == 0 ? 5 : s == 2 ? 6 : 4);
      end
      tally_and_finish;
   end
endmodule // ext_mem_sdram_pdt_bus_hold_tb
`default_nettype wire
